// file: core/acd_decoder.sv
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// R1: msb zero decodes as register access command.
// R2: msb one decodes as conversion or calibration command.
// R3: array flag set transfers all registers of type, channel 0 upward, msb first.
// R4: low three bits pick offset 001, gain 010, config 011, setup 101; others reserved.
// R5: bit 3 decides write into or read out of selected registers.
// R6: bit 6 clear gives single settled conversion, set gives continuous.
// R7: bits 5..3 point to one of eight stored setups.
// R8: low bits: conv 000, self ofs 001, self gain 010, sys ofs 101, sys gain 110.
// R9: bits 5..4 pick the channel when the array flag is clear.
// R10: direction bit clear means write, set means read.
module acd_decoder (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             sclk_i,
  input  wire logic             sdi_i,
  input  wire logic             cmd_mode_i,
  output var  acd_pkg::acd_cmd_type cmd_o,
  output logic                  cmd_strobe_o,
  output logic                  cmd_reserved_o
);
  import acd_pkg::*;

  // ==========================================================================
  // link side: shift the command byte on sclk rising edges
  logic [7:0] shift_q;
  logic [2:0] bitcnt;
  logic [7:0] byte_l;
  logic       tog_l;
  logic [7:0] next_shift_q;
  logic [2:0] next_bitcnt;
  logic [7:0] next_byte_l;
  logic       next_tog_l;
  logic       mode_s1;
  logic       mode_s2;

  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_s1 <= 1'b0;
      mode_s2 <= 1'b0;
    end else begin
      mode_s1 <= cmd_mode_i;
      mode_s2 <= mode_s1;
    end
  end

  always_comb begin
    next_shift_q = {shift_q[6:0], sdi_i};
    next_bitcnt  = bitcnt + 3'h1;
    next_byte_l  = byte_l;
    next_tog_l   = tog_l;
    if (!mode_s2) begin
      next_bitcnt = BITCNT_RST;
    end else if (bitcnt == BITCNT_LAST) begin
      // byte held stable until the next full byte, so the toggle crossing is safe
      next_byte_l = next_shift_q;
      next_tog_l  = ~tog_l;
    end
  end

  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_q <= SHIFT_RST;
      bitcnt  <= BITCNT_RST;
      byte_l  <= SHIFT_RST;
      tog_l   <= 1'b0;
    end else begin
      shift_q <= next_shift_q;
      bitcnt  <= next_bitcnt;
      byte_l  <= next_byte_l;
      tog_l   <= next_tog_l;
    end
  end

  // ==========================================================================
  // system side: toggle synchroniser and decode
  logic        tog_s1;
  logic        tog_s2;
  logic        tog_s3;
  acd_cmd_type next_cmd;
  logic        next_strobe;
  logic        next_reserved;
  logic        new_byte;

  assign new_byte = tog_s2 ^ tog_s3;

  always_comb begin
    next_cmd      = cmd_o;
    next_strobe   = 1'b0;
    next_reserved = cmd_reserved_o;
    if (new_byte) begin
      next_strobe = 1'b1;
      next_cmd    = CMD_RST;
      next_cmd.is_conv = byte_l[BIT_CLASS];                              // [R1] [R2]
      if (!byte_l[BIT_CLASS]) begin
        next_cmd.array_access_flag   = byte_l[BIT_ARRAY];               // [R3]
        next_cmd.channel_pick_bits   = byte_l[CH_HI:CH_LO];             // [R9]
        next_cmd.is_read             = byte_l[BIT_DIR];                 // [R5] [R10]
        next_cmd.register_type_field = byte_l[SEL_HI:SEL_LO];           // [R4]
        case (byte_l[SEL_HI:SEL_LO])
          RT_OFFSET, RT_GAIN, RT_CONFIG, RT_SETUP: next_cmd.valid = 1'b1; // [R4]
          default: next_cmd.valid = 1'b0;
        endcase
      end else begin
        next_cmd.continuous_conversion_flag = byte_l[BIT_CONT];         // [R6]
        next_cmd.setup_pointer              = byte_l[PTR_HI:PTR_LO];    // [R7]
        next_cmd.operation_select_field     = byte_l[SEL_HI:SEL_LO];    // [R8]
        case (byte_l[SEL_HI:SEL_LO])
          OP_CONV, OP_SELF_OFS, OP_SELF_GN, OP_SYS_OFS, OP_SYS_GN: next_cmd.valid = 1'b1; // [R8]
          default: next_cmd.valid = 1'b0;
        endcase
      end
      next_reserved = ~next_cmd.valid;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tog_s1         <= 1'b0;
      tog_s2         <= 1'b0;
      tog_s3         <= 1'b0;
      cmd_o          <= CMD_RST;
      cmd_strobe_o   <= 1'b0;
      cmd_reserved_o <= 1'b0;
    end else begin
      tog_s1         <= tog_l;
      tog_s2         <= tog_s1;
      tog_s3         <= tog_s2;
      cmd_o          <= next_cmd;
      cmd_strobe_o   <= next_strobe;
      cmd_reserved_o <= next_reserved;
    end
  end

  // ==========================================================================
  // checks
  property p_class_split;
    @(posedge clk_i) disable iff (!rst_n_i)
      cmd_strobe_o |-> (cmd_o.is_conv == $past(byte_l[BIT_CLASS]));
  endproperty
  a_class_split: assert property (p_class_split) else $error("class bit mismatch"); // [R1] [R2]

  property p_reg_fields;
    @(posedge clk_i) disable iff (!rst_n_i)
      (cmd_strobe_o && !cmd_o.is_conv) |-> (cmd_o.array_access_flag == $past(byte_l[6])
        && cmd_o.channel_pick_bits == $past(byte_l[5:4]));
  endproperty
  a_reg_fields: assert property (p_reg_fields) else $error("register fields wrong"); // [R3] [R9]

  property p_reg_type;
    @(posedge clk_i) disable iff (!rst_n_i)
      (cmd_strobe_o && !cmd_o.is_conv) |->
        (cmd_o.valid == (cmd_o.register_type_field inside {3'h1, 3'h2, 3'h3, 3'h5}));
  endproperty
  a_reg_type: assert property (p_reg_type) else $error("register type validity wrong"); // [R4]

  property p_dir;
    @(posedge clk_i) disable iff (!rst_n_i)
      (cmd_strobe_o && !cmd_o.is_conv) |-> (cmd_o.is_read == $past(byte_l[3]));
  endproperty
  a_dir: assert property (p_dir) else $error("direction wrong"); // [R5] [R10]

  property p_cont;
    @(posedge clk_i) disable iff (!rst_n_i)
      (cmd_strobe_o && cmd_o.is_conv) |-> (cmd_o.continuous_conversion_flag == $past(byte_l[6]));
  endproperty
  a_cont: assert property (p_cont) else $error("continuous flag wrong"); // [R6]

  property p_ptr;
    @(posedge clk_i) disable iff (!rst_n_i)
      (cmd_strobe_o && cmd_o.is_conv) |-> (cmd_o.setup_pointer == $past(byte_l[5:3]));
  endproperty
  a_ptr: assert property (p_ptr) else $error("setup pointer wrong"); // [R7]

  property p_op;
    @(posedge clk_i) disable iff (!rst_n_i)
      (cmd_strobe_o && cmd_o.is_conv) |->
        (cmd_o.valid == !(cmd_o.operation_select_field inside {3'h3, 3'h4, 3'h7}));
  endproperty
  a_op: assert property (p_op) else $error("operation validity wrong"); // [R8]

  property p_strobe_one;
    @(posedge clk_i) disable iff (!rst_n_i)
      cmd_strobe_o |=> (!cmd_strobe_o && $stable(cmd_o));
  endproperty
  a_strobe_one: assert property (p_strobe_one) else $error("strobe longer than one cycle");

  property p_reg_sel;
    @(posedge clk_i) disable iff (!rst_n_i)
      (cmd_strobe_o && !cmd_o.is_conv) |-> (cmd_o.register_type_field == $past(byte_l[2:0]));
  endproperty
  a_reg_sel: assert property (p_reg_sel) else $error("register type field wrong"); // [R4]

  property p_op_sel;
    @(posedge clk_i) disable iff (!rst_n_i)
      (cmd_strobe_o && cmd_o.is_conv) |-> (cmd_o.operation_select_field == $past(byte_l[2:0]));
  endproperty
  a_op_sel: assert property (p_op_sel) else $error("operation field wrong"); // [R8]

  // fields of the other class stay zero, so no stale bits reach the user
  property p_class_clean;
    @(posedge clk_i) disable iff (!rst_n_i)
      cmd_strobe_o |-> (cmd_o.is_conv ?
        (!cmd_o.array_access_flag && cmd_o.channel_pick_bits == 2'h0
          && !cmd_o.is_read && cmd_o.register_type_field == 3'h0) :
        (!cmd_o.continuous_conversion_flag && cmd_o.setup_pointer == 3'h0
          && cmd_o.operation_select_field == 3'h0));
  endproperty
  a_class_clean: assert property (p_class_clean) else $error("other class fields not cleared"); // [R1] [R2]

  property p_reserved_flag;
    @(posedge clk_i) disable iff (!rst_n_i)
      cmd_strobe_o |-> (cmd_reserved_o == !cmd_o.valid);
  endproperty
  a_reserved_flag: assert property (p_reserved_flag) else $error("reserved flag wrong"); // [R4] [R8]

  // decoded command stands until the next strobe
  property p_held;
    @(posedge clk_i) disable iff (!rst_n_i)
      !cmd_strobe_o |-> ($stable(cmd_o) && $stable(cmd_reserved_o));
  endproperty
  a_held: assert property (p_held) else $error("command changed without strobe");

  c_reg_read:  cover property (@(posedge clk_i) disable iff (!rst_n_i) cmd_strobe_o && !cmd_o.is_conv && cmd_o.is_read);
  c_array:     cover property (@(posedge clk_i) disable iff (!rst_n_i) cmd_strobe_o && cmd_o.array_access_flag);
  c_cont_conv: cover property (@(posedge clk_i) disable iff (!rst_n_i) cmd_strobe_o && cmd_o.continuous_conversion_flag);
  c_reserved:  cover property (@(posedge clk_i) disable iff (!rst_n_i) cmd_strobe_o && cmd_reserved_o);
  c_calib:     cover property (@(posedge clk_i) disable iff (!rst_n_i)
                 cmd_strobe_o && cmd_o.is_conv && cmd_o.valid && cmd_o.operation_select_field != OP_CONV);

endmodule // acd_decoder

`default_nettype wire

// file: core/acd_pkg.sv
package acd_pkg;

  // ==========================================================================
  // command byte layout
  localparam int CMD_W          = 8;
  localparam int BIT_CLASS      = 7;
  localparam int BIT_ARRAY      = 6;
  localparam int BIT_CONT       = 6;
  localparam int BIT_DIR        = 3;
  localparam int CH_HI          = 5;
  localparam int CH_LO          = 4;
  localparam int PTR_HI         = 5;
  localparam int PTR_LO         = 3;
  localparam int SEL_HI         = 2;
  localparam int SEL_LO         = 0;

  // ==========================================================================
  // register type codes
  localparam logic [2:0] RT_OFFSET = 3'h1;
  localparam logic [2:0] RT_GAIN   = 3'h2;
  localparam logic [2:0] RT_CONFIG = 3'h3;
  localparam logic [2:0] RT_SETUP  = 3'h5;

  // ==========================================================================
  // operation codes
  localparam logic [2:0] OP_CONV     = 3'h0;
  localparam logic [2:0] OP_SELF_OFS = 3'h1;
  localparam logic [2:0] OP_SELF_GN  = 3'h2;
  localparam logic [2:0] OP_SYS_OFS  = 3'h5;
  localparam logic [2:0] OP_SYS_GN   = 3'h6;

  // ==========================================================================
  // reset values and last bit count
  localparam logic [2:0] BITCNT_RST = 3'h0;
  localparam logic [2:0] BITCNT_LAST = 3'h7;
  localparam logic [7:0] SHIFT_RST  = 8'h00;

  typedef struct packed {
    logic       valid;        // decoded command is usable
    logic       is_conv;      // conversion/calibration class
    logic       array_access_flag;
    logic [1:0] channel_pick_bits;
    logic       is_read;
    logic [2:0] register_type_field;
    logic       continuous_conversion_flag;
    logic [2:0] setup_pointer;
    logic [2:0] operation_select_field;
  } acd_cmd_type;

  localparam acd_cmd_type CMD_RST = '0;

endpackage

// file: testbench/acd_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// controller side of the command port
module acd_host_model (
  output var logic sclk_o,
  output var logic sdi_o,
  output var logic cmd_mode_o
);
  initial begin
    sclk_o     = 1'b0;
    sdi_o      = 1'b0;
    cmd_mode_o = 1'b0;
  end

  // sdi changes after the falling edge, design samples on the rising one
  task automatic pulse(input logic d);
    sdi_o <= d;
    #15 sclk_o <= 1'b1;
    #15 sclk_o <= 1'b0;
  endtask

  // n bits of w, msb first, inside one command-mode frame
  task automatic send(input logic [15:0] w, input int n);
    cmd_mode_o <= 1'b1;
    pulse(1'b1);
    pulse(1'b0);
    for (int i = 0; i < n; i++) begin
      pulse(w[15-i]);
    end
    cmd_mode_o <= 1'b0;
    // sync flops still pass two edges; tail bits form a discarded partial byte
    repeat (3) pulse(~sdi_o);
    // clock stands still between frames, data line not holding old bit
    sdi_o <= ~sdi_o;
    // keeps a following frame out of this time step
    #15;
  endtask
endmodule // acd_host_model

`default_nettype wire

// file: testbench/adc_command_byte_decoder_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

module adc_command_byte_decoder_tb_top;
  import acd_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  wire logic   sclk_i;
  wire logic   sdi_i;
  wire logic   cmd_mode_i;
  acd_cmd_type cmd_o;
  logic        cmd_strobe_o;
  logic        cmd_reserved_o;
  acd_cmd_type got_q[$];
  logic        res_q[$];
  int          errors = 0;
  int          n_compared = 0;
  int          cycles = 0;

  always #25 clk_i = ~clk_i;

  acd_decoder i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .sdi_i(sdi_i),
    .cmd_mode_i(cmd_mode_i), .cmd_o(cmd_o), .cmd_strobe_o(cmd_strobe_o), .cmd_reserved_o(cmd_reserved_o));
  acd_host_model i_host (.sclk_o(sclk_i), .sdi_o(sdi_i), .cmd_mode_o(cmd_mode_i));

  always @(posedge clk_i) begin
    if (cmd_strobe_o === 1'b1) begin
      got_q.push_back(cmd_o);
      res_q.push_back(cmd_reserved_o);
    end
  end

  function automatic acd_cmd_type expect_cmd(input logic [7:0] b);
    acd_cmd_type e;
    e = '0;
    e.is_conv = b[7];
    if (b[7]) begin
      e.continuous_conversion_flag = b[6];
      e.setup_pointer              = b[5:3];
      e.operation_select_field     = b[2:0];
      e.valid = b[2:0] inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    end else begin
      e.array_access_flag   = b[6];
      e.channel_pick_bits   = b[5:4];
      e.is_read             = b[3];
      e.register_type_field = b[2:0];
      e.valid = b[2:0] inside {3'h1, 3'h2, 3'h3, 3'h5};
    end
    return e;
  endfunction

  task automatic check(input logic [7:0] b);
    acd_cmd_type e;
    acd_cmd_type g;
    logic        r;
    int          k;
    e = expect_cmd(b);
    k = 0;
    while (got_q.size() == 0 && k < 60) begin
      @(posedge clk_i);
      k++;
    end
    `CHK(got_q.size() > 0, 1'b1)
    if (got_q.size() > 0) begin
      g = got_q.pop_front();
      r = res_q.pop_front();
      `CHK(g.valid, e.valid)
      `CHK(r, ~e.valid)
      if (e.valid) begin
        `CHK(g.is_conv, e.is_conv)
        `CHK(g.array_access_flag, e.array_access_flag)
        `CHK(g.channel_pick_bits, e.channel_pick_bits)
        `CHK(g.is_read, e.is_read)
        `CHK(g.register_type_field, e.register_type_field)
        `CHK(g.continuous_conversion_flag, e.continuous_conversion_flag)
        `CHK(g.setup_pointer, e.setup_pointer)
        `CHK(g.operation_select_field, e.operation_select_field)
      end
    end
  endtask

  task automatic test_done();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    `CHK(cmd_strobe_o, 1'b0)
    `CHK(cmd_o, CMD_RST)
    `CHK(cmd_reserved_o, 1'b0)
    // every byte: both classes, all codes, pointers and channels
    for (int i = 0; i < 256; i++) begin
      i_host.send({i[7:0], 8'h00}, 8);
      check(i[7:0]);
    end
    // partial byte is dropped with the mode
    i_host.send(16'hA500, 3);
    repeat (10) @(posedge clk_i);
    `CHK(got_q.size(), 0)
    // last command of the sweep still stands
    @(negedge clk_i);
    `CHK(cmd_o, expect_cmd(8'hFF))
    `CHK(cmd_reserved_o, 1'b1)
    // reset in mid-run clears the decoded command
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    `CHK(cmd_o, CMD_RST)
    `CHK(cmd_reserved_o, 1'b0)
    i_host.send(16'h9100, 8);
    check(8'h91);
    // two bytes back to back in one frame
    i_host.send(16'hC82B, 16);
    check(8'hC8);
    check(8'h2B);
    test_done();
  end
endmodule // adc_command_byte_decoder_tb_top

`default_nettype wire
